// file: aps_defines.svh
// constants for the converter power, alert and sequencer control block
// assumes inclusion by bare name from the block; the package does not include it
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH

// configuration word bit positions
`define APS_CFG_REF_BIT      0
`define APS_CFG_SLEEP_BIT    1
`define APS_CFG_POL_BIT      3
`define APS_CFG_PINEN_BIT    4
`define APS_CFG_BUSYSEL_BIT  5
`define APS_CFG_DRIVE_BIT    15

// reset values
`define APS_CFG_RESET        16'h0000
`define APS_CHSEL_RESET      4'h0

// conversion time of the modelled core
`define APS_CONV_NS          600
`define APS_CLK_NS           20
`define APS_CONV_CYCLES      ((`APS_CONV_NS + `APS_CLK_NS - 1) / `APS_CLK_NS)

`endif

// file: aps_pkg.sv
// types shared by the power, alert and sequencer control block
// uses no macro from aps_defines.svh and does not include it
`default_nettype none

package aps_pkg;

    typedef enum logic [1:0] {
        APS_IDLE,
        APS_CONV,
        APS_DONE
    } aps_state_e;

    typedef struct packed {
        aps_state_e  state;
        logic [15:0] conv_count;
        logic [3:0]  active_sel;
        logic [3:0]  pending_sel;
        logic        pending;
        logic [1:0]  chan;
        logic [11:0] result;
        logic [1:0]  result_chan;
        logic [7:0]  alert_flags;
        logic        alert_any;
        logic        busy;
        logic        pin_out;
        logic        pin_oe;
        logic        analog_on;
        logic        ref_on;
        logic        conv_done;
        logic        start_meta;
        logic        start_sync;
    } aps_state_s;

endpackage : aps_pkg

`default_nettype wire

// file: aps_sequencer.sv
// power-down, out-of-bounds alert, shared status pin and channel sequencer
// assumes a register front end on mclk drives config, strobes and limits;
// conv_start_req comes from a pin and is synchronised here
`default_nettype none
`include "aps_defines.svh"

module aps_sequencer #(
    parameter int CHANNELS    = 4,
    parameter int DATA_WIDTH  = 12,
    parameter int CONV_CYCLES = `APS_CONV_CYCLES
) (
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic                         soft_reset,
    input  wire logic [15:0]                  config_word,
    input  wire logic [CHANNELS-1:0]          channel_select,
    input  wire logic                         channel_select_write,
    input  wire logic                         alert_status_read,
    input  wire logic                         conv_start_req,
    input  wire logic [DATA_WIDTH-1:0]        sample_value,
    input  wire logic [CHANNELS*DATA_WIDTH-1:0] limit_high,
    input  wire logic [CHANNELS*DATA_WIDTH-1:0] limit_low,
    input  wire logic [CHANNELS*DATA_WIDTH-1:0] hysteresis,
    output logic [DATA_WIDTH-1:0]             conv_result,
    output logic [1:0]                        conv_channel,
    output logic                              conv_alert,
    output logic [2*CHANNELS-1:0]             alert_status,
    output logic                              conv_done,
    output logic                              busy,
    output logic                              analog_power_on,
    output logic                              reference_power_on,
    output logic                              shared_status_pin_o,
    output logic                              shared_status_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks: state struct is sized for four 12-bit channels

    if (CHANNELS != 4) begin : g_bad_channels
        $error("aps_sequencer serves exactly four channels");
    end
    if (DATA_WIDTH != 12) begin : g_bad_width
        $error("aps_sequencer serves 12-bit results only");
    end
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
        $error("aps_sequencer conversion count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // lowest enabled channel at or above start, wrapping; empty mask gives 0
    function automatic logic [1:0] next_enabled(input logic [3:0] mask,
                                                input logic [1:0] start);
        logic [1:0] idx;
        logic [1:0] found;
        logic       hit;
        found = 2'h0;
        hit   = 1'b0;
        for (int i = 0; i < 4; i++) begin
            idx = start + i[1:0];
            if (!hit && mask[idx]) begin
                found = idx;
                hit   = 1'b1;
            end
        end
        return found;
    endfunction : next_enabled

    ////////////////////////////////////////////////////////////////////////
    // per-channel limit compare

    logic [CHANNELS-1:0] over_high;
    logic [CHANNELS-1:0] under_low;
    logic [CHANNELS-1:0] clear_high;
    logic [CHANNELS-1:0] clear_low;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_cmp
            logic [DATA_WIDTH-1:0] hi;
            logic [DATA_WIDTH-1:0] lo;
            logic [DATA_WIDTH-1:0] hy;
            assign hi = limit_high[g*DATA_WIDTH +: DATA_WIDTH];
            assign lo = limit_low[g*DATA_WIDTH +: DATA_WIDTH];
            assign hy = hysteresis[g*DATA_WIDTH +: DATA_WIDTH];
            assign over_high[g]  = sample_value > hi;
            assign under_low[g]  = sample_value < lo;
            // wider sums avoid wrap when sample or limit plus hysteresis overflows
            assign clear_high[g] = {1'b0, sample_value} + {1'b0, hy} < {1'b0, hi};
            assign clear_low[g]  = {1'b0, sample_value} > {1'b0, lo} + {1'b0, hy};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // state

    aps_pkg::aps_state_s st;
    aps_pkg::aps_state_s next_st;

    logic common_alert;
    logic want_busy_pin;
    logic want_alert_pin;
    logic pin_active;
    logic [1:0] ch;

    always_comb begin
        next_st = st;
        ch      = st.chan;

        // start request from a pin: two flops before use
        next_st.start_meta = conv_start_req;
        next_st.start_sync = st.start_meta;
        next_st.conv_done  = 1'b0;

        // power control follows the two-bit field; bit 0 alone owns the reference
        next_st.ref_on    = config_word[`APS_CFG_REF_BIT];
        next_st.analog_on = config_word[`APS_CFG_SLEEP_BIT];

        // a selection write is held until the running conversion ends
        if (channel_select_write) begin
            next_st.pending_sel = channel_select;
            next_st.pending     = 1'b1;
        end

        case (st.state)
            aps_pkg::APS_IDLE: begin
                if (st.pending || channel_select_write) begin
                    next_st.active_sel = channel_select_write ? channel_select
                                                              : st.pending_sel;
                    next_st.chan    = next_enabled(next_st.active_sel, 2'h0);
                    next_st.pending = 1'b0;
                end
                if (st.start_sync && st.analog_on) begin
                    next_st.state      = aps_pkg::APS_CONV;
                    next_st.conv_count = 16'(CONV_CYCLES - 1);
                    next_st.busy       = 1'b1;
                end
            end
            aps_pkg::APS_CONV: begin
                if (st.conv_count == 16'h0000) begin
                    next_st.state = aps_pkg::APS_DONE;
                end else begin
                    next_st.conv_count = st.conv_count - 16'h0001;
                end
            end
            aps_pkg::APS_DONE: begin
                next_st.result      = sample_value;
                next_st.result_chan = ch;
                next_st.busy        = 1'b0;
                next_st.conv_done   = 1'b1;
                if (st.pending || channel_select_write) begin
                    next_st.active_sel = channel_select_write ? channel_select
                                                              : st.pending_sel;
                    next_st.chan    = next_enabled(next_st.active_sel, 2'h0);
                    next_st.pending = 1'b0;
                end else begin
                    next_st.chan = next_enabled(st.active_sel, ch + 2'h1);
                end
                next_st.state = aps_pkg::APS_IDLE;
            end
            default: begin
                next_st.state = aps_pkg::APS_IDLE;
            end
        endcase

        // alert flags: hardware set beats a read clear in the same cycle
        if (alert_status_read) begin
            next_st.alert_flags = 8'h00;
        end
        if (st.state == aps_pkg::APS_DONE) begin
            if (over_high[ch]) begin
                next_st.alert_flags[2*ch+1] = 1'b1;
            end else if (clear_high[ch]) begin
                next_st.alert_flags[2*ch+1] = 1'b0;
            end
            if (under_low[ch]) begin
                next_st.alert_flags[2*ch] = 1'b1;
            end else if (clear_low[ch]) begin
                next_st.alert_flags[2*ch] = 1'b0;
            end
        end
        if (soft_reset) begin
            next_st.alert_flags = 8'h00;
            next_st.pending     = 1'b0;
            next_st.pending_sel = `APS_CHSEL_RESET;
            next_st.active_sel  = `APS_CHSEL_RESET;
            next_st.chan        = 2'h0;
        end

        // pin: built from the next values so it lines up with the flag flops
        common_alert   = |next_st.alert_flags;
        // registered copy keeps the result alert bit straight off a flop
        next_st.alert_any = common_alert;
        want_alert_pin = config_word[`APS_CFG_PINEN_BIT]
                       & ~config_word[`APS_CFG_BUSYSEL_BIT];
        want_busy_pin  = config_word[`APS_CFG_PINEN_BIT]
                       & config_word[`APS_CFG_BUSYSEL_BIT];
        pin_active     = (want_alert_pin & common_alert)
                       | (want_busy_pin & next_st.busy);
        if (config_word[`APS_CFG_DRIVE_BIT]) begin
            // push-pull: drive both levels
            next_st.pin_out = pin_active ^ ~config_word[`APS_CFG_POL_BIT];
            next_st.pin_oe  = want_alert_pin | want_busy_pin;
        end else begin
            // open-drain: only pull low; pull-up gives the high level
            next_st.pin_out = 1'b0;
            next_st.pin_oe  = (want_alert_pin | want_busy_pin)
                            & (pin_active ^ config_word[`APS_CFG_POL_BIT]);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{state:       aps_pkg::APS_IDLE,
                    conv_count:  16'h0000,
                    active_sel:  `APS_CHSEL_RESET,
                    pending_sel: `APS_CHSEL_RESET,
                    pending:     1'b0,
                    chan:        2'h0,
                    result:      12'h000,
                    result_chan: 2'h0,
                    alert_flags: 8'h00,
                    alert_any:   1'b0,
                    busy:        1'b0,
                    pin_out:     1'b0,
                    pin_oe:      1'b0,
                    analog_on:   1'b0,
                    ref_on:      1'b0,
                    conv_done:   1'b0,
                    start_meta:  1'b0,
                    start_sync:  1'b0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state flops

    assign conv_result          = st.result;
    assign conv_channel         = st.result_chan;
    assign conv_alert           = st.alert_any;
    assign alert_status         = st.alert_flags;
    assign conv_done            = st.conv_done;
    assign busy                 = st.busy;
    assign analog_power_on      = st.analog_on;
    assign reference_power_on   = st.ref_on;
    assign shared_status_pin_o  = st.pin_out;
    assign shared_status_pin_oe = st.pin_oe;

endmodule : aps_sequencer

`default_nettype wire

// file: aps_sequencer_chk.sv
// concurrent checks on the power, alert and sequencer control block
// assumes binding to aps_sequencer; sees only its ports on mclk
`default_nettype none

module aps_sequencer_chk #(
    parameter int CHANNELS   = 4,
    parameter int DATA_WIDTH = 12
) (
    input wire logic                  mclk,
    input wire logic                  resetn,
    input wire logic                  soft_reset,
    input wire logic [15:0]           config_word,
    input wire logic                  alert_status_read,
    input wire logic [DATA_WIDTH-1:0] conv_result,
    input wire logic [1:0]            conv_channel,
    input wire logic                  conv_alert,
    input wire logic [2*CHANNELS-1:0] alert_status,
    input wire logic                  conv_done,
    input wire logic                  busy,
    input wire logic                  analog_power_on,
    input wire logic                  reference_power_on,
    input wire logic                  shared_status_pin_o,
    input wire logic                  shared_status_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // wanted pin level; the mode bits pick busy or the common alert
    wire logic pin_lvl = (config_word[5] ? busy : conv_alert) ~^ config_word[3];
    sequence s_done_end;
        conv_done && !busy;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////////////
    AST_DONE_ONE: assert property (s_done_end |=> !conv_done && $past(busy, 2))
        else $error("conversion end pulse malformed");
    AST_BUSY_FALL: assert property ($fell(busy) |-> conv_done)
        else $error("busy fell without a stored result");
    AST_ALERT_OR: assert property (conv_alert == |alert_status)
        else $error("common alert differs from flag OR");
    AST_FLAGS_HOLD: assert property (!conv_done && !$past(alert_status_read) &&
        !$past(soft_reset) |-> $stable(alert_status)) else $error("flags moved unasked");
    AST_READ_CLEAR: assert property ($past(alert_status_read) && !$past(soft_reset) &&
        !conv_done |-> alert_status == '0) else $error("status read left flags");
    AST_SOFT_CLEAR: assert property ($past(soft_reset) |-> alert_status == '0 && !conv_alert)
        else $error("soft reset left alert status");
    AST_NO_START: assert property (!analog_power_on |=> !$rose(busy))
        else $error("conversion started while unpowered");
    AST_RESULT_HOLD: assert property (!conv_done |-> $stable(conv_result) &&
        $stable(conv_channel)) else $error("result changed without conversion");
    AST_POWER: assert property ($past(resetn) |-> reference_power_on == $past(config_word[0]) &&
        analog_power_on == $past(config_word[1])) else $error("power state wrong");
    AST_OPEN_DRAIN: assert property (!config_word[15] && $stable(config_word) && $past(resetn)
        |-> !(shared_status_pin_oe && shared_status_pin_o)) else $error("open drain drove high");
    AST_PIN_LEVEL: assert property ($past(resetn) && $stable(config_word) && config_word[4] &&
        $stable(busy) && $stable(conv_alert) |-> (config_word[15] ? (shared_status_pin_oe &&
        shared_status_pin_o == pin_lvl) : shared_status_pin_oe == !pin_lvl))
        else $error("shared pin level wrong");
endmodule : aps_sequencer_chk

bind aps_sequencer aps_sequencer_chk #(.CHANNELS(CHANNELS), .DATA_WIDTH(DATA_WIDTH)) i_chk (
    .mclk(mclk), .resetn(resetn), .soft_reset(soft_reset), .config_word(config_word),
    .alert_status_read(alert_status_read), .conv_result(conv_result),
    .conv_channel(conv_channel), .conv_alert(conv_alert), .alert_status(alert_status),
    .conv_done(conv_done), .busy(busy), .analog_power_on(analog_power_on),
    .reference_power_on(reference_power_on), .shared_status_pin_o(shared_status_pin_o),
    .shared_status_pin_oe(shared_status_pin_oe));

`default_nettype wire

// file: aps_core_model.sv
// analog core stand-in: presents the sample the bench asks for
// assumes the block samples sample_value in its completion cycle
`default_nettype none

module aps_core_model (
    input  wire logic        mclk,
    input  wire logic        analog_power_on,
    input  wire logic [11:0] level,
    output var  logic [11:0] sample_value
);
    timeunit 1ns;
    timeprecision 1ns;
    // an unpowered core has no valid sample, so the line keeps toggling
    always @(posedge mclk) sample_value <= analog_power_on ? level : ~sample_value;
endmodule : aps_core_model

`default_nettype wire

// file: aps_sequencer_tb_top.sv
// self-checking bench for the power, alert and sequencer control block
// assumes the checker is bound in; conversions shortened to 2 cycles
`default_nettype none

module aps_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, resetn, soft_reset, channel_select_write, alert_status_read;
    logic        conv_start_req, conv_done, busy, analog_power_on, reference_power_on;
    logic        conv_alert, shared_status_pin_o, shared_status_pin_oe;
    logic [15:0] config_word;
    logic [3:0]  channel_select;
    logic [11:0] sample_value, level, conv_result;
    logic [1:0]  conv_channel;
    logic [7:0]  alert_status;
    logic [47:0] limit_high, limit_low, hysteresis;
    int          fails, samples_checked;

    always #10 mclk = ~mclk;
    aps_sequencer #(.CONV_CYCLES(2)) i_aps_sequencer (.mclk, .resetn, .soft_reset,
        .config_word, .channel_select, .channel_select_write, .alert_status_read,
        .conv_start_req, .sample_value, .limit_high, .limit_low, .hysteresis, .conv_result,
        .conv_channel, .conv_alert, .alert_status, .conv_done, .busy, .analog_power_on,
        .reference_power_on, .shared_status_pin_o, .shared_status_pin_oe);
    aps_core_model i_aps_core_model (.mclk, .analog_power_on, .level, .sample_value);
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // bounded wait for busy or for the completion pulse, looked at on the falling edge
    task automatic wait_on(input bit on_busy);
        int n;
        n = 0;
        while ((on_busy ? busy : conv_done) !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        if ((on_busy ? busy : conv_done) !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask : wait_on

    task automatic cfg(input logic [15:0] v);
        @(posedge mclk);
        config_word <= v;
        repeat (2) @(negedge mclk);
    endtask : cfg

    task automatic sel(input logic [3:0] m);
        @(posedge mclk);
        channel_select <= m;
        channel_select_write <= 1'b1;
        @(posedge mclk);
        channel_select_write <= 1'b0;
    endtask : sel

    task automatic pulse(input bit rd);
        @(posedge mclk);
        if (rd) alert_status_read <= 1'b1;
        else soft_reset <= 1'b1;
        @(posedge mclk);
        alert_status_read <= 1'b0;
        soft_reset <= 1'b0;
        @(negedge mclk);
    endtask : pulse

    // one conversion; optionally a new mask is written while it runs
    task automatic convert(input logic [11:0] v, input logic [1:0] ch, input bit wr,
                           input logic [3:0] m);
        @(posedge mclk);
        level <= v;
        conv_start_req <= 1'b1;
        @(posedge mclk);
        conv_start_req <= 1'b0;
        repeat (2) @(posedge mclk);
        if (wr) sel(m);
        wait_on(1'b0);
        chk(16'(conv_channel), 16'(ch));
        chk(16'(conv_result), 16'(v));
    endtask : convert
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0; resetn = 1'b0; soft_reset = 1'b0; channel_select_write = 1'b0;
        alert_status_read = 1'b0; conv_start_req = 1'b0; config_word = 16'h0003;
        channel_select = 4'h0; level = 12'h000; fails = 0; samples_checked = 0;
        limit_high = {4{12'h800}}; limit_low = {4{12'h100}}; hysteresis = {4{12'h010}};
        repeat (6) @(posedge mclk);
        chk(16'({analog_power_on, busy, conv_done, shared_status_pin_oe}), 16'h0000);
        resetn <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(16'({analog_power_on, reference_power_on}), 16'h0003);
        sel(4'h0);
        convert(12'h400, 2'h0, 1'b0, 4'h0);
        convert(12'h401, 2'h0, 1'b0, 4'h0);
        sel(4'ha);
        convert(12'h402, 2'h1, 1'b0, 4'h0);
        convert(12'h403, 2'h3, 1'b1, 4'h4);
        convert(12'h404, 2'h2, 1'b0, 4'h0);
        convert(12'h405, 2'h2, 1'b0, 4'h0);
        cfg(16'h0001);
        chk(16'({analog_power_on, reference_power_on}), 16'h0001);
        cfg(16'h0000);
        @(posedge mclk);
        conv_start_req <= 1'b1;
        @(posedge mclk);
        conv_start_req <= 1'b0;
        repeat (8) @(negedge mclk);
        chk(16'({busy, conv_result}), 16'h0405);
        cfg(16'h0013);
        // reference settle wait, scaled far down to keep the run short
        repeat (4) @(negedge mclk);
        sel(4'h1);
        convert(12'h900, 2'h0, 1'b0, 4'h0);
        chk(16'(alert_status), 16'h0002);
        chk(16'({conv_alert, shared_status_pin_oe, shared_status_pin_o}), 16'h0006);
        pulse(1'b1);
        chk(16'({alert_status, conv_alert, shared_status_pin_oe}), 16'h0000);
        convert(12'h050, 2'h0, 1'b0, 4'h0);
        chk(16'(alert_status), 16'h0001);
        convert(12'h105, 2'h0, 1'b0, 4'h0);
        chk(16'(alert_status), 16'h0001);
        convert(12'h120, 2'h0, 1'b0, 4'h0);
        chk(16'(alert_status), 16'h0000);
        convert(12'h900, 2'h0, 1'b0, 4'h0);
        pulse(1'b0);
        chk(16'({alert_status, conv_alert}), 16'h0000);
        cfg(16'h803b);
        @(posedge mclk);
        conv_start_req <= 1'b1;
        @(posedge mclk);
        conv_start_req <= 1'b0;
        wait_on(1'b1);
        chk(16'({shared_status_pin_oe, shared_status_pin_o}), 16'h0003);
        wait_on(1'b0);
        chk(16'({busy, shared_status_pin_oe, shared_status_pin_o}), 16'h0002);
        stop_test();
    end
endmodule : aps_sequencer_tb_top

`default_nettype wire
